// ==== hdl/codec_power_control_register.sv ====
// Codec power control register bank with APB slave and power sequencing
//
// Notes on behaviour
// - Bit 15 high powers the whole codec down; resets to 1.
// - Bit 14 reserved, always reads 0; software writes 0 only.
// - Bit 13 high keeps analog sidetone powered down; resets to 1.
// - Bit 12 picks driver power mode, 0 low and 1 high; resets 0.
// - Bit 11 reads 1 once sidetone power-down is finished; resets 1.
// - Bit 10 high powers the DAC down; resets to 1.
// - Bit 9 high powers the ADC down; resets to 1.
// - Bit 8 high powers virtual-ground amplifier down; resets to 1.
// - Bit 7 reads 1 once ADC power-down completes; resets 1.
// - Bit 6 reads 1 once DAC power-down completes; resets 1.
// - Bit 5 picks word-select pin role: 0 power-down input, 1 word select.
// - With shared rate the DAC word clock may serve as ADC word select.
// - Bit 4 picks bias level: 0 gives 2.5 V, 1 gives 2.0 V.
// - Bits 3 to 2 reserved, read 00; software writes 00 only.
// - Bit 1 enables the effects filter; resets 0.
// - Bit 0 enables de-emphasis filter; resets 0.
//
// Chosen here: register access over APB.
`timescale 1ns/100ps
module codec_power_control_register (
	// Clock and reset
	input  wire logic        clk,
	input  wire logic        rst,
	input  wire logic        ce,
	// APB slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// Word-select pins
	input  wire logic        adc_word_select_pin,
	input  wire logic        dac_word_clock,
	input  wire logic        use_shared_word_clock,
	// Power and mode controls
	output logic             codec_power_down,
	output logic             analog_sidetone_power_down,
	output logic             output_driver_power_mode,
	output logic             dac_power_down,
	output logic             adc_power_down,
	output logic             virtual_ground_amp_power_down,
	output logic             bias_output_level,
	output logic             effects_filter_enable,
	output logic             deemphasis_enable,
	output logic             adc_word_select,
	// Interrupt
	output logic             irq
);
	import codec_power_pkg::*;

	logic [15:0]          ctrl_q;
	logic [NUM_PATHS-1:0] irq_status_q;
	logic [NUM_PATHS-1:0] irq_enable_q;
	logic [NUM_PATHS-1:0] off_flags;
	logic [NUM_PATHS-1:0] done_pulses;
	logic [NUM_PATHS-1:0] pd_reqs;
	logic                 hw_pin_pd;
	logic                 wr_en;
	logic                 rd_en;
	logic [15:0]          power_view;

	function automatic logic addr_known(input logic [11:0] a);
		return (a == ADDR_POWER) || (a == ADDR_IRQ_STATUS) ||
			(a == ADDR_IRQ_CLEAR) || (a == ADDR_IRQ_ENABLE);
	endfunction

	// =====================================================
	// APB access decode: zero wait states
	assign wr_en = psel && penable && pwrite && ce;
	assign rd_en = psel && penable && !pwrite && ce;

	// =====================================================
	// Pin role: in power-down mode the pin forces ADC path down
	assign hw_pin_pd = !ctrl_q[BIT_WS_ROLE] && adc_word_select_pin;

	// Path order: 0 sidetone, 1 ADC, 2 DAC; codec power-down forces all down
	assign pd_reqs[0] = ctrl_q[BIT_CODEC_PD] || ctrl_q[BIT_SIDETONE_PD];
	assign pd_reqs[1] = ctrl_q[BIT_CODEC_PD] || ctrl_q[BIT_ADC_PD] || hw_pin_pd;
	assign pd_reqs[2] = ctrl_q[BIT_CODEC_PD] || ctrl_q[BIT_DAC_PD];

	genvar g;
	generate
		for (g = 0; g < NUM_PATHS; g++) begin : g_path
			path_ctrl_if pc ();
			assign pc.pd_req      = pd_reqs[g];
			assign off_flags[g]   = pc.off_flag;
			assign done_pulses[g] = pc.done_pulse;
			path_sequencer u_seq (
				.clk (clk),
				.rst (rst),
				.ce  (ce),
				.pc  (pc)
			);
		end
	endgenerate

	// =====================================================
	// Read view: flags from sequencers, reserved bits zero
	always_comb begin
		power_view                   = ctrl_q & POWER_WRITE_MASK;
		power_view[BIT_SIDETONE_OFF] = off_flags[0];
		power_view[BIT_ADC_OFF]      = off_flags[1];
		power_view[BIT_DAC_OFF]      = off_flags[2];
	end

	// =====================================================
	// Control register: only writable fields take data
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			ctrl_q <= POWER_RESET & POWER_WRITE_MASK;
		end else if (wr_en && paddr == ADDR_POWER) begin
			ctrl_q <= pwdata[15:0] & POWER_WRITE_MASK;
		end
	end

	// =====================================================
	// Interrupt status: set wins over clear
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			irq_status_q <= IRQ_RESET;
		end else if (ce) begin
			if (wr_en && paddr == ADDR_IRQ_CLEAR) begin
				irq_status_q <= (irq_status_q & ~pwdata[NUM_PATHS-1:0]) | done_pulses;
			end else begin
				irq_status_q <= irq_status_q | done_pulses;
			end
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			irq_enable_q <= IRQ_RESET;
		end else if (wr_en && paddr == ADDR_IRQ_ENABLE) begin
			irq_enable_q <= pwdata[NUM_PATHS-1:0];
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			irq <= 1'b0;
		end else if (ce) begin
			irq <= |(irq_status_q & irq_enable_q);
		end
	end

	// =====================================================
	// APB response, registered
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			prdata  <= 32'h0;
			pready  <= 1'b0;
			pslverr <= 1'b0;
		end else if (ce) begin
			pready  <= psel && !penable;
			pslverr <= psel && !penable && !addr_known(paddr);
			prdata  <= 32'h0;
			if (psel && !penable && !pwrite) begin
				case (paddr)
					ADDR_POWER:      prdata <= {16'h0, power_view};
					ADDR_IRQ_STATUS: prdata <= {29'h0, irq_status_q};
					ADDR_IRQ_ENABLE: prdata <= {29'h0, irq_enable_q};
					default:         prdata <= 32'h0;
				endcase
			end
		end
	end

	// =====================================================
	// Registered control outputs
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			codec_power_down              <= POWER_RESET[BIT_CODEC_PD];
			analog_sidetone_power_down    <= POWER_RESET[BIT_SIDETONE_PD];
			output_driver_power_mode      <= POWER_RESET[BIT_DRV_MODE];
			dac_power_down                <= POWER_RESET[BIT_DAC_PD];
			adc_power_down                <= POWER_RESET[BIT_ADC_PD];
			virtual_ground_amp_power_down <= POWER_RESET[BIT_VIRTUAL_GROUND_PD];
			bias_output_level             <= POWER_RESET[BIT_BIAS_LEVEL];
			effects_filter_enable         <= POWER_RESET[BIT_EFFECTS];
			deemphasis_enable             <= POWER_RESET[BIT_DEEMPH];
			adc_word_select               <= 1'b0;
		end else if (ce) begin
			codec_power_down              <= ctrl_q[BIT_CODEC_PD];
			analog_sidetone_power_down    <= pd_reqs[0];
			output_driver_power_mode      <= ctrl_q[BIT_DRV_MODE];
			dac_power_down                <= pd_reqs[2];
			adc_power_down                <= pd_reqs[1];
			virtual_ground_amp_power_down <= ctrl_q[BIT_CODEC_PD] || ctrl_q[BIT_VIRTUAL_GROUND_PD];
			bias_output_level             <= ctrl_q[BIT_BIAS_LEVEL];
			effects_filter_enable         <= ctrl_q[BIT_EFFECTS];
			deemphasis_enable             <= ctrl_q[BIT_DEEMPH];
			// Shared rate lets the DAC word clock stand in for the pin
			adc_word_select <= use_shared_word_clock ? dac_word_clock :
				(ctrl_q[BIT_WS_ROLE] ? adc_word_select_pin : 1'b0);
		end
	end

	// =====================================================
	// Checks
	sequence s_write_power;
		psel && penable && pwrite && ce && paddr == ADDR_POWER;
	endsequence

	sequence s_read_power;
		psel && !penable && !pwrite && ce && paddr == ADDR_POWER;
	endsequence

	property p_reserved_zero;
		@(posedge clk) disable iff (rst)
		(psel && !penable && !pwrite && paddr == ADDR_POWER && ce) |=>
			(prdata[BIT_RSVD14] == 1'b0 && prdata[3:2] == 2'b00);
	endproperty
	a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bits nonzero");

	property p_codec_pd;
		@(posedge clk) disable iff (rst)
		(s_write_power ##1 ce) |=> codec_power_down == $past(pwdata[BIT_CODEC_PD], 2);
	endproperty
	a_codec_pd: assert property (p_codec_pd) else $error("codec power down mismatch");

	property p_drv_mode;
		@(posedge clk) disable iff (rst)
		(s_write_power ##1 ce) |=> output_driver_power_mode == $past(pwdata[BIT_DRV_MODE], 2);
	endproperty
	a_drv_mode: assert property (p_drv_mode) else $error("driver mode mismatch");

	property p_dac_off_flag;
		@(posedge clk) disable iff (rst)
		(ce && !pd_reqs[2] && !done_pulses[2]) |=> !off_flags[2];
	endproperty
	a_dac_off_flag: assert property (p_dac_off_flag) else $error("dac flag set while powering up");

	property p_adc_pd_force;
		@(posedge clk) disable iff (rst)
		(ce && ctrl_q[BIT_CODEC_PD]) |=> adc_power_down;
	endproperty
	a_adc_pd_force: assert property (p_adc_pd_force) else $error("adc not down with codec down");

	property p_side_off_done;
		@(posedge clk) disable iff (rst)
		$rose(off_flags[0]) |-> $past(done_pulses[0]);
	endproperty
	a_side_off_done: assert property (p_side_off_done) else $error("sidetone flag rose early");

	property p_ro_flag_write;
		@(posedge clk) disable iff (rst)
		s_write_power |=> ctrl_q[BIT_ADC_OFF] == 1'b0 && ctrl_q[BIT_DAC_OFF] == 1'b0;
	endproperty
	a_ro_flag_write: assert property (p_ro_flag_write) else $error("read-only bit stored");

	property p_adc_flag_settle;
		@(posedge clk) disable iff (rst)
		$fell(pd_reqs[1]) ##0 (off_flags[1] && ce) |=> !off_flags[1];
	endproperty
	a_adc_flag_settle: assert property (p_adc_flag_settle) else $error("adc flag stayed set");

	property p_deemph;
		@(posedge clk) disable iff (rst)
		(s_write_power ##1 ce) |=> deemphasis_enable == $past(pwdata[BIT_DEEMPH], 2);
	endproperty
	a_deemph: assert property (p_deemph) else $error("deemphasis mismatch");

	property p_sidetone_pd;
		@(posedge clk) disable iff (rst)
		(ce && (ctrl_q[BIT_CODEC_PD] || ctrl_q[BIT_SIDETONE_PD])) |=>
			analog_sidetone_power_down;
	endproperty
	a_sidetone_pd: assert property (p_sidetone_pd) else $error("sidetone not down");

	property p_dac_pd;
		@(posedge clk) disable iff (rst)
		(ce && ctrl_q[BIT_DAC_PD]) |=> dac_power_down;
	endproperty
	a_dac_pd: assert property (p_dac_pd) else $error("dac not down");

	property p_virtual_ground_pd;
		@(posedge clk) disable iff (rst)
		(ce && ctrl_q[BIT_VIRTUAL_GROUND_PD]) |=> virtual_ground_amp_power_down;
	endproperty
	a_virtual_ground_pd: assert property (p_virtual_ground_pd) else $error("virtual ground amp not down");

	property p_virtual_ground_up;
		@(posedge clk) disable iff (rst)
		(ce && !ctrl_q[BIT_CODEC_PD] && !ctrl_q[BIT_VIRTUAL_GROUND_PD]) |=>
			!virtual_ground_amp_power_down;
	endproperty
	a_virtual_ground_up: assert property (p_virtual_ground_up) else $error("virtual ground amp not up");

	property p_bias;
		@(posedge clk) disable iff (rst)
		ce |=> bias_output_level == $past(ctrl_q[BIT_BIAS_LEVEL]);
	endproperty
	a_bias: assert property (p_bias) else $error("bias level mismatch");

	property p_effects;
		@(posedge clk) disable iff (rst)
		ce |=> effects_filter_enable == $past(ctrl_q[BIT_EFFECTS]);
	endproperty
	a_effects: assert property (p_effects) else $error("effects enable mismatch");

	property p_ws_role;
		@(posedge clk) disable iff (rst)
		(ce && !use_shared_word_clock && !ctrl_q[BIT_WS_ROLE]) |=> !adc_word_select;
	endproperty
	a_ws_role: assert property (p_ws_role) else $error("word select in power-down role");

	property p_ws_shared;
		@(posedge clk) disable iff (rst)
		(ce && use_shared_word_clock) |=> adc_word_select == $past(dac_word_clock);
	endproperty
	a_ws_shared: assert property (p_ws_shared) else $error("shared word clock mismatch");

	property p_pin_pd;
		@(posedge clk) disable iff (rst)
		(ce && !ctrl_q[BIT_WS_ROLE] && adc_word_select_pin) |=> adc_power_down;
	endproperty
	a_pin_pd: assert property (p_pin_pd) else $error("pin did not power adc down");

	property p_flag_view;
		@(posedge clk) disable iff (rst)
		s_read_power |=> prdata[BIT_SIDETONE_OFF] == $past(off_flags[0]);
	endproperty
	a_flag_view: assert property (p_flag_view) else $error("sidetone flag read mismatch");

	property p_dac_flag_done;
		@(posedge clk) disable iff (rst)
		done_pulses[2] |=> off_flags[2];
	endproperty
	a_dac_flag_done: assert property (p_dac_flag_done) else $error("dac flag not set");

	property p_irq_sticky;
		@(posedge clk) disable iff (rst)
		done_pulses[1] |=> irq_status_q[1];
	endproperty
	a_irq_sticky: assert property (p_irq_sticky) else $error("adc event lost");

	property p_frozen;
		@(posedge clk) disable iff (rst)
		!ce |=> $stable(ctrl_q) && $stable(irq_status_q) && $stable(off_flags);
	endproperty
	a_frozen: assert property (p_frozen) else $error("state moved with clock enable low");

	property p_pready_one;
		@(posedge clk) disable iff (rst)
		(psel && !penable && ce) |=> pready;
	endproperty
	a_pready_one: assert property (p_pready_one) else $error("no ready in access cycle");
endmodule

// ==== hdl/codec_power_pkg.sv ====
// Package of register map, field positions and timing for the codec power control block
package codec_power_pkg;
	// =====================================================
	// Register map
	localparam logic [7:0]  REG_INDEX_POWER      = 8'h05;
	localparam logic [11:0] ADDR_POWER           = 12'h014;
	localparam logic [11:0] ADDR_IRQ_STATUS      = 12'h040;
	localparam logic [11:0] ADDR_IRQ_CLEAR       = 12'h044;
	localparam logic [11:0] ADDR_IRQ_ENABLE      = 12'h048;
	// =====================================================
	// Field positions of the power register
	localparam int BIT_CODEC_PD     = 15;
	localparam int BIT_RSVD14       = 14;
	localparam int BIT_SIDETONE_PD  = 13;
	localparam int BIT_DRV_MODE     = 12;
	localparam int BIT_SIDETONE_OFF = 11;
	localparam int BIT_DAC_PD       = 10;
	localparam int BIT_ADC_PD       = 9;
	localparam int BIT_VIRTUAL_GROUND_PD      = 8;
	localparam int BIT_ADC_OFF      = 7;
	localparam int BIT_DAC_OFF      = 6;
	localparam int BIT_WS_ROLE      = 5;
	localparam int BIT_BIAS_LEVEL   = 4;
	localparam int BIT_EFFECTS      = 1;
	localparam int BIT_DEEMPH       = 0;
	localparam logic [15:0] POWER_WRITE_MASK = 16'hb73f & 16'hfff3;
	localparam logic [15:0] POWER_RESET      = 16'hafc0;
	// =====================================================
	// Interrupt events: one per completion flag
	localparam int NUM_PATHS = 3;
	localparam logic [NUM_PATHS-1:0] IRQ_RESET = 3'h0;
	// =====================================================
	// Power-down settling time per path
	localparam int SETTLE_NS     = 1000;
	localparam int CLK_PERIOD_NS = 25;
	localparam int SETTLE_CYCLES = SETTLE_NS / CLK_PERIOD_NS;
	localparam int CNT_W         = 6;
	localparam logic [CNT_W-1:0] CNT_ZERO = 6'h00;
	localparam logic [CNT_W-1:0] CNT_LOAD = CNT_W'(SETTLE_CYCLES);
	typedef enum logic [1:0] {
		ST_OFF     = 2'b00,
		ST_RAMP_UP = 2'b01,
		ST_ON      = 2'b11,
		ST_RAMP_DN = 2'b10
	} path_state_type;
endpackage

// ==== hdl/path_ctrl_if.sv ====
// Interface between the register bank and a power path sequencer
`timescale 1ns/100ps
interface path_ctrl_if;
	logic pd_req;
	logic off_flag;
	logic done_pulse;
	modport bank (output pd_req, input off_flag, input done_pulse);
	modport seq  (input pd_req, output off_flag, output done_pulse);
endinterface

// ==== hdl/path_sequencer.sv ====
// Power-down sequencer for one analog path with completion flag
`timescale 1ns/100ps
module path_sequencer (
	// Clock and reset
	input  wire logic clk,
	input  wire logic rst,
	input  wire logic ce,
	// Control
	path_ctrl_if.seq  pc
);
	import codec_power_pkg::*;

	path_state_type               state_q;
	logic [CNT_W-1:0]             cnt_q;

	// =====================================================
	// Sequence: ramp for a settling time in either direction
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			state_q <= ST_OFF;
			cnt_q   <= CNT_ZERO;
		end else if (ce) begin
			case (state_q)
				ST_OFF: begin
					if (!pc.pd_req) begin
						state_q <= ST_RAMP_UP;
						cnt_q   <= CNT_LOAD;
					end
				end
				ST_RAMP_UP: begin
					if (pc.pd_req) begin
						state_q <= ST_RAMP_DN;
						cnt_q   <= CNT_LOAD;
					end else if (cnt_q == CNT_ZERO) begin
						state_q <= ST_ON;
					end else begin
						cnt_q <= cnt_q - 1'b1;
					end
				end
				ST_ON: begin
					if (pc.pd_req) begin
						state_q <= ST_RAMP_DN;
						cnt_q   <= CNT_LOAD;
					end
				end
				ST_RAMP_DN: begin
					if (cnt_q == CNT_ZERO) begin
						state_q <= ST_OFF;
					end else begin
						cnt_q <= cnt_q - 1'b1;
					end
				end
				default: begin
					state_q <= ST_OFF;
				end
			endcase
		end
	end

	// Flag is 1 only once fully off
	assign pc.off_flag   = (state_q == ST_OFF);
	assign pc.done_pulse = ce && (state_q == ST_RAMP_DN) && (cnt_q == CNT_ZERO);
endmodule

// ==== tb/codec_power_control_register_test.sv ====
// Self-checking bench for the codec power control register block
`timescale 1ns/100ps
module codec_power_control_register_test;
	import codec_power_pkg::*;
	// ==========================================
	// Design hookup
	logic        clk;
	logic        rst;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [11:0] paddr;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        ws_pin;
	logic        wclk;
	logic        shared;
	logic [9:0]  outs;
	logic        irq;
	logic        ce_in;
	int          err_total;
	int          cmp_count;
	logic [31:0] rdat;
	logic        rerr;
	codec_power_control_register i_codec_power_control_register (
		.clk(clk), .rst(rst), .ce(ce_in),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.adc_word_select_pin(ws_pin), .dac_word_clock(wclk),
		.use_shared_word_clock(shared),
		.codec_power_down(outs[9]), .analog_sidetone_power_down(outs[8]),
		.output_driver_power_mode(outs[7]), .dac_power_down(outs[6]),
		.adc_power_down(outs[5]), .virtual_ground_amp_power_down(outs[4]),
		.bias_output_level(outs[3]), .effects_filter_enable(outs[2]),
		.deemphasis_enable(outs[1]), .adc_word_select(outs[0]), .irq(irq)
	);
	always #12.5 clk = ~clk;
	// ==========================================
	// Tasks
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			err_total++;
			$display("FAIL %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	// Holds the request until pready is sampled high
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
		int n;
		n = 0;
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= wd;
		@(posedge clk);
		penable <= 1'b1;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1);
		chk("pready wait", n, 1);
		rdat = prdata;
		rerr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic rdc(input logic [11:0] a, input logic [31:0] exp, input string nm);
		apb(1'b0, a, 32'h0);
		chk(nm, rdat, exp);
	endtask
	task automatic stop_test;
		$display("comparisons %0d mismatches %0d", cmp_count, err_total);
		if (err_total == 0 && cmp_count > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	// ==========================================
	// Watchdog
	initial begin
		#(25 * 5000);
		err_total++;
		stop_test;
	end
	// ==========================================
	// Tests
	initial begin
		clk = 1'b0;
		rst = 1'b1;
		{psel, penable, pwrite, ws_pin, wclk, shared} = 6'h00;
		ce_in = 1'b1;
		paddr = 12'h000;
		pwdata = 32'h0;
		err_total = 0;
		cmp_count = 0;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		cyc(1);
		chk("outs rst", {22'h0, outs}, 32'h370);
		rdc(ADDR_POWER, 32'hafc0, "pwr rst");
		rdc(ADDR_IRQ_STATUS, 32'h0, "sts rst");
		rdc(12'h0f0, 32'h0, "unmapped");
		chk("slverr", {31'h0, rerr}, 32'h1);
		// Flag bits must ignore the write; reserved bits stay zero
		apb(1'b1, ADDR_POWER, 32'hbff3);
		rdc(ADDR_POWER, 32'hbff3, "pwr ones");
		chk("slverr ok", {31'h0, rerr}, 32'h0);
		cyc(2);
		chk("outs ones", {22'h0, outs}, 32'h3fe);
		// Pin kept as word select while the ADC runs
		apb(1'b1, ADDR_POWER, 32'h0020);
		cyc(3);
		rdc(ADDR_POWER, 32'h0020, "pwr up");
		chk("outs up", {22'h0, outs}, 32'h0);
		// Power-down ramp with interrupt enabled
		apb(1'b1, ADDR_IRQ_ENABLE, 32'h7);
		rdc(ADDR_IRQ_ENABLE, 32'h7, "ena");
		apb(1'b1, ADDR_POWER, 32'ha700);
		rdc(ADDR_POWER, 32'ha700, "pwr ramp");
		cyc(50);
		rdc(ADDR_POWER, 32'hafc0, "pwr done");
		chk("irq set", {31'h0, irq}, 32'h1);
		rdc(ADDR_IRQ_STATUS, 32'h7, "sts set");
		apb(1'b1, ADDR_IRQ_STATUS, 32'h0);
		rdc(ADDR_IRQ_STATUS, 32'h7, "sts ro");
		apb(1'b1, ADDR_IRQ_CLEAR, 32'h7);
		rdc(ADDR_IRQ_CLEAR, 32'h0, "clr wo");
		rdc(ADDR_IRQ_STATUS, 32'h0, "sts clr");
		cyc(2);
		chk("irq clr", {31'h0, irq}, 32'h0);
		// Masked event stays sticky but quiet
		apb(1'b1, ADDR_IRQ_ENABLE, 32'h0);
		apb(1'b1, ADDR_POWER, 32'h0020);
		cyc(3);
		apb(1'b1, ADDR_POWER, 32'ha700);
		cyc(50);
		rdc(ADDR_IRQ_STATUS, 32'h7, "sts mask");
		chk("irq mask", {31'h0, irq}, 32'h0);
		// Word-select pin role and shared word clock
		apb(1'b1, ADDR_POWER, 32'h0220);
		ws_pin <= 1'b1;
		cyc(3);
		chk("ws pin", {31'h0, outs[0]}, 32'h1);
		apb(1'b1, ADDR_POWER, 32'h0200);
		cyc(3);
		chk("ws pd", {31'h0, outs[0]}, 32'h0);
		@(posedge clk);
		shared <= 1'b1;
		wclk <= 1'b1;
		cyc(3);
		chk("ws shr1", {31'h0, outs[0]}, 32'h1);
		@(posedge clk);
		wclk <= 1'b0;
		cyc(3);
		chk("ws shr0", {31'h0, outs[0]}, 32'h0);
		// Clock enable low freezes the registered outputs
		@(posedge clk);
		ce_in <= 1'b0;
		wclk <= 1'b1;
		cyc(3);
		chk("ce hold", {31'h0, outs[0]}, 32'h0);
		@(posedge clk);
		ce_in <= 1'b1;
		cyc(3);
		chk("ce run", {31'h0, outs[0]}, 32'h1);
		stop_test;
	end
endmodule
